// ---- design/power_clock_switch.v ----
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "power_clock_map.vh"
module power_clock_switch #(
	parameter PLL_LOCK_CYC = `PLL_LOCK_CYC,
	parameter OST_EDGES = `OST_EDGES,
	parameter INT_STABLE_EDGES = `INT_STABLE_EDGES
) (
	input wire clk_sys,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	input wire sleepReq,
	input wire wakeReq,
	input wire crystalPllMode,
	input wire priIsInternal,
	input wire wdtEnable,
	input wire failSafeEnable,
	input wire priOscPin,
	input wire secOscPin,
	input wire intFastPin,
	input wire intSlowPin,
	output reg cpuClkEn,
	output reg periphClkEn,
	output reg priOscEn,
	output reg secOscEn,
	output reg intFastEn,
	output reg slowRcEn
);
	// fsm states, one-hot
	localparam [4:0] ST_RUN = 5'h01; // steady on curSrc_r
	localparam [4:0] ST_WAITPRI = 5'h02; // old clock kept while primary starts
	localparam [4:0] ST_HOLD = 5'h04; // clocks stopped until timer osc starts
	localparam [4:0] ST_OLD = 5'h08; // counting outgoing edges
	localparam [4:0] ST_NEW = 5'h10; // counting incoming edges

	// software state
	reg idleOnSleep_r; // idle_on_sleep
	reg [2:0] intFreqSel_r; // int_freq_sel
	reg [1:0] clkSrcSel_r; // clk_src_sel
	reg secOscEnable_r; // sec_osc_enable
	reg lowFreqSrcSel_r; // low_freq_src_sel

	// mode state
	reg [4:0] state_r;
	reg [4:0] state_nxt;
	reg [1:0] curSrc_r; // source now clocking the device
	reg [1:0] tgtSrc_r; // source being switched to
	reg [1:0] tgtSrc_nxt;
	reg [1:0] edgeCnt_r; // edges counted in ST_OLD / ST_NEW
	reg [1:0] edgeCnt_nxt;
	reg sleep_r; // full sleep, all clocks off
	reg idle_r; // cpu stopped, peripherals run

	// oscillator readiness
	reg primReady_r;
	reg [10:0] ostCnt_r; // osc_startup_counter
	reg [16:0] pllCnt_r;
	reg secStarted_r;
	reg [7:0] intStbCnt_r;
	reg intStable_r;

	// status flags, registered
	reg primaryReadyFlag_r; // primary_ready_flag
	reg intFastStableFlag_r; // int_fast_stable_flag
	reg secOscRunningFlag_r; // sec_osc_running_flag

	wire [3:0] oscEdge; // pri, sec, fast, slow
	wire intTick;
	reg oldEdge;
	reg newEdge;
	reg srcTick;
	reg [1:0] reqSrc;
	wire apbWrite;
	wire apbSetup;

	osc_edge_sync #(
		.N(4)
	) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.oscIn({intSlowPin, intFastPin, secOscPin, priOscPin}),
		.oscEdge(oscEdge)
	);

	// rate picked live from the field
	int_postscaler u_post (
		.clk_sys(clk_sys),
		.reset(reset),
		.fastEdge(oscEdge[2]),
		.slowEdge(oscEdge[3]),
		.freqSel(intFreqSel_r),
		.lowFreqSrcSel(lowFreqSrcSel_r),
		.intTick(intTick)
	);

	// zero-wait slave: read data is loaded in the setup cycle
	assign pready = psel & penable;
	assign apbWrite = psel & penable & pwrite;
	assign apbSetup = psel & ~penable;

	// read data and error answer
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (apbSetup)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			case (paddr)
				`OSC_CTRL_OFS:
				begin
					prdata[`OSC_IDLE_BIT] <= idleOnSleep_r;
					prdata[`OSC_FREQ_HI:`OSC_FREQ_LO] <= intFreqSel_r;
					prdata[`OSC_PRI_RDY_BIT] <= primaryReadyFlag_r;
					prdata[`OSC_INT_STB_BIT] <= intFastStableFlag_r;
					prdata[`OSC_SEL_HI:`OSC_SEL_LO] <= clkSrcSel_r;
				end
				`SEC_TIMER_CTRL_OFS:
				begin
					prdata[`SECONDARY_RUN_BIT] <= secOscRunningFlag_r;
					prdata[`SEC_EN_BIT] <= secOscEnable_r;
				end
				`OSC_TUNE_OFS:
					prdata[`TUNE_LFS_BIT] <= lowFreqSrcSel_r;
				`MODE_STAT_OFS:
				begin
					prdata[`STAT_SLEEP_BIT] <= sleep_r;
					prdata[`STAT_IDLE_BIT] <= idle_r;
					prdata[`STAT_SRC_HI:`STAT_SRC_LO] <= curSrc_r;
					prdata[`STAT_SWITCH_BIT] <= ~state_r[0];
				end
				default:
					pslverr <= 1'b1; // unmapped address
			endcase
		end
	end

	// software writes; flags and status bits are read only
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			idleOnSleep_r <= 1'b0;
			intFreqSel_r <= `FREQ_SEL_RST;
			clkSrcSel_r <= `CLK_SEL_RST;
			secOscEnable_r <= 1'b0;
			lowFreqSrcSel_r <= 1'b0;
		end
		else if (apbWrite)
		begin
			case (paddr)
				`OSC_CTRL_OFS:
				begin
					idleOnSleep_r <= pwdata[`OSC_IDLE_BIT];
					intFreqSel_r <= pwdata[`OSC_FREQ_HI:`OSC_FREQ_LO];
					clkSrcSel_r <= pwdata[`OSC_SEL_HI:`OSC_SEL_LO];
				end
				`SEC_TIMER_CTRL_OFS:
					secOscEnable_r <= pwdata[`SEC_EN_BIT];
				`OSC_TUNE_OFS:
					lowFreqSrcSel_r <= pwdata[`TUNE_LFS_BIT];
				default:
					secOscEnable_r <= secOscEnable_r; // ignored
			endcase
		end
	end

	// decode the wanted source from the select field
	always @*
	begin
		if (clkSrcSel_r[1])
			reqSrc = `SRC_INT; // lower bit ignored
		else if (clkSrcSel_r[0] && !secOscEnable_r)
			reqSrc = curSrc_r;
		else
			reqSrc = clkSrcSel_r;
	end

	// per-source edge pick for outgoing, incoming and current clock
	always @*
	begin
		case (curSrc_r)
			`SRC_PRI: oldEdge = oscEdge[0];
			`SRC_SEC: oldEdge = oscEdge[1];
			default: oldEdge = intTick;
		endcase
		case (tgtSrc_r)
			`SRC_PRI: newEdge = oscEdge[0];
			`SRC_SEC: newEdge = oscEdge[1];
			default: newEdge = intTick;
		endcase
		srcTick = oldEdge;
	end

	// switch sequencer
	always @*
	begin
		state_nxt = state_r;
		tgtSrc_nxt = tgtSrc_r;
		edgeCnt_nxt = edgeCnt_r;
		case (state_r)
			ST_RUN:
			begin
				if (reqSrc != curSrc_r && !sleep_r)
				begin
					tgtSrc_nxt = reqSrc;
					edgeCnt_nxt = 2'h0;
					// internal-to-internal-primary still pays this path
					if (reqSrc == `SRC_PRI)
						state_nxt = ST_WAITPRI;
					else if (reqSrc == `SRC_SEC && !secStarted_r)
						state_nxt = ST_HOLD;
					else
						state_nxt = ST_OLD;
				end
			end
			ST_WAITPRI:
			begin
				// old source keeps clocking meanwhile
				if (reqSrc != `SRC_PRI)
					state_nxt = ST_RUN;
				else if (primReady_r)
					state_nxt = ST_OLD;
			end
			ST_HOLD:
			begin
				if (!secOscEnable_r)
					state_nxt = ST_RUN; // enable withdrawn, stay put
				else if (secStarted_r)
					state_nxt = ST_NEW;
			end
			ST_OLD:
			begin
				if (oldEdge)
				begin
					edgeCnt_nxt = edgeCnt_r + 2'h1;
					if (edgeCnt_r == `OLD_EDGES - 1)
					begin
						edgeCnt_nxt = 2'h0;
						state_nxt = ST_NEW;
					end
				end
			end
			ST_NEW:
			begin
				if (newEdge)
				begin
					edgeCnt_nxt = edgeCnt_r + 2'h1;
					if (edgeCnt_r == `NEW_EDGES - 1)
					begin
						edgeCnt_nxt = 2'h0;
						state_nxt = ST_RUN;
					end
				end
			end
			default:
				state_nxt = ST_RUN;
		endcase
	end

	// sequencer, source and low-power state
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_r <= ST_RUN;
			curSrc_r <= `SRC_PRI;
			tgtSrc_r <= `SRC_PRI;
			edgeCnt_r <= 2'h0;
			sleep_r <= 1'b0;
			idle_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			tgtSrc_r <= tgtSrc_nxt;
			edgeCnt_r <= edgeCnt_nxt;
			if (state_r == ST_NEW && state_nxt == ST_RUN)
				curSrc_r <= tgtSrc_r;
			// wake and sleep meeting in one cycle: sleep wins, it is newer
			if (wakeReq)
			begin
				sleep_r <= 1'b0;
				idle_r <= 1'b0;
			end
			if (sleepReq)
			begin
				// idle flag sampled at this very request
				if (!idleOnSleep_r)
					sleep_r <= 1'b1;
				else if (!(clkSrcSel_r == `SRC_SEC && !secOscEnable_r))
					idle_r <= 1'b1;
			end
		end
	end

	// primary start-up: 1024 edges, then pll lock when selected
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			primReady_r <= 1'b1;
			ostCnt_r <= 11'h000;
			pllCnt_r <= 17'h0_0000;
		end
		else if (!priOscEn)
		begin
			primReady_r <= 1'b0;
			ostCnt_r <= 11'h000;
			pllCnt_r <= 17'h0_0000;
		end
		else if (!primReady_r)
		begin
			if (ostCnt_r != OST_EDGES[10:0])
			begin
				if (oscEdge[0])
					ostCnt_r <= ostCnt_r + 11'h001;
			end
			else if (!crystalPllMode || pllCnt_r == PLL_LOCK_CYC[16:0] - 17'h0_0001)
				primReady_r <= 1'b1;
			else
				pllCnt_r <= pllCnt_r + 17'h0_0001;
		end
	end

	// timer oscillator seen oscillating while enabled
	always @(posedge clk_sys)
	begin
		if (reset)
			secStarted_r <= 1'b0;
		else if (!secOscEnable_r)
			secStarted_r <= 1'b0;
		else if (oscEdge[1])
			secStarted_r <= 1'b1;
	end

	// fast internal output settling; counter survives select changes that keep intFastEn on
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			intStbCnt_r <= 8'h00;
			intStable_r <= 1'b0;
		end
		else if (!intFastEn)
		begin
			intStbCnt_r <= 8'h00;
			intStable_r <= 1'b0;
		end
		else if (!intStable_r && oscEdge[2])
		begin
			intStbCnt_r <= intStbCnt_r + 8'h01;
			if (intStbCnt_r == INT_STABLE_EDGES[7:0] - 8'h01)
				intStable_r <= 1'b1;
		end
	end

	// oscillator enables, clock gating and status flags
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			priOscEn <= 1'b1;
			secOscEn <= 1'b0;
			intFastEn <= 1'b0;
			slowRcEn <= 1'b0;
			cpuClkEn <= 1'b0;
			periphClkEn <= 1'b0;
			primaryReadyFlag_r <= 1'b1;
			intFastStableFlag_r <= 1'b0;
			secOscRunningFlag_r <= 1'b0;
		end
		else
		begin
			// primary runs only while used or wanted; off in sleep
			priOscEn <= !sleep_r && (curSrc_r == `SRC_PRI
				|| (state_r != ST_RUN && tgtSrc_r == `SRC_PRI));
			secOscEn <= secOscEnable_r; // left running
			intFastEn <= !sleep_r && (intFreqSel_r != 3'h0 || lowFreqSrcSel_r);
			slowRcEn <= wdtEnable || failSafeEnable
				|| (!sleep_r && intFreqSel_r == 3'h0 && !lowFreqSrcSel_r
				&& (curSrc_r == `SRC_INT || tgtSrc_r == `SRC_INT));
			// gap during the switch window and while holding for the oscillator
			periphClkEn <= srcTick && !sleep_r && (state_r == ST_RUN
				|| state_r == ST_WAITPRI);
			cpuClkEn <= srcTick && !sleep_r && !idle_r && (state_r == ST_RUN
				|| state_r == ST_WAITPRI);
			// flags follow the committed source; sleep clears them all
			primaryReadyFlag_r <= !sleep_r && curSrc_r == `SRC_PRI
				&& primReady_r;
			secOscRunningFlag_r <= !sleep_r && curSrc_r == `SRC_SEC;
			intFastStableFlag_r <= !sleep_r && intStable_r && intFastEn
				&& (curSrc_r == `SRC_INT
				|| (curSrc_r == `SRC_PRI && priIsInternal));
		end
	end
endmodule // power_clock_switch

// ---- design/power_clock_map.vh ----
`ifndef POWER_CLOCK_MAP_VH
`define POWER_CLOCK_MAP_VH

// register byte offsets on the apb window
`define OSC_CTRL_OFS 8'h00
`define SEC_TIMER_CTRL_OFS 8'h04
`define OSC_TUNE_OFS 8'h08
`define MODE_STAT_OFS 8'h0C

// osc_control_reg fields
`define OSC_IDLE_BIT 7
`define OSC_FREQ_HI 6
`define OSC_FREQ_LO 4
`define OSC_PRI_RDY_BIT 3
`define OSC_INT_STB_BIT 2
`define OSC_SEL_HI 1
`define OSC_SEL_LO 0

// sec_timer_ctrl_reg fields
`define SECONDARY_RUN_BIT 6
`define SEC_EN_BIT 3

// tuning register field
`define TUNE_LFS_BIT 7

// mode status fields
`define STAT_SLEEP_BIT 0
`define STAT_IDLE_BIT 1
`define STAT_SRC_HI 3
`define STAT_SRC_LO 2
`define STAT_SWITCH_BIT 4

// reset values
`define FREQ_SEL_RST 3'h4
`define CLK_SEL_RST 2'h0

// clock source codes
`define SRC_PRI 2'h0
`define SRC_SEC 2'h1
`define SRC_INT 2'h2

// timing
`define CLK_PERIOD_NS 20
`define OST_EDGES 1024
`define PLL_LOCK_NS 2000000
`define PLL_LOCK_CYC (`PLL_LOCK_NS / `CLK_PERIOD_NS)
`define OLD_EDGES 2
`define NEW_EDGES 3
`define INT_STABLE_EDGES 64

`endif

// ---- design/osc_edge_sync.v ----
`timescale 1ns/10ps
// brings free-running oscillator pins into clk_sys and marks their rising edges
module osc_edge_sync #(
	parameter N = 4
) (
	input wire clk_sys,
	input wire reset,
	input wire [N-1:0] oscIn,
	output wire [N-1:0] oscEdge
);
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1)
		begin : g_sync
			reg meta_r; // first stage, read only by the second
			reg sync_r; // second stage
			reg prev_r; // delayed copy for edge detection
			reg edge_r; // registered rising-edge pulse
			// two flops before any logic, then edge detect
			always @(posedge clk_sys)
			begin
				if (reset)
				begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
					prev_r <= 1'b0;
					edge_r <= 1'b0;
				end
				else
				begin
					meta_r <= oscIn[i];
					sync_r <= meta_r;
					prev_r <= sync_r;
					edge_r <= sync_r & ~prev_r;
				end
			end
			assign oscEdge[i] = edge_r;
		end
	endgenerate
endmodule // osc_edge_sync

// ---- design/int_postscaler.v ----
`timescale 1ns/10ps
// divides the fast internal output; 000 picks slow rc or fast/256
module int_postscaler (
	input wire clk_sys,
	input wire reset,
	input wire fastEdge,
	input wire slowEdge,
	input wire [2:0] freqSel,
	input wire lowFreqSrcSel,
	output reg intTick
);
	reg [7:0] divCnt_r; // free-running, so a rate change acts at once
	reg [7:0] mask; // low bits that must all be set for a tick
	// mask is 2^(7-sel)-1 for 001 to 111, FF for 000; 111 passes every fast edge
	always @*
	begin
		mask = 8'hFF >> freqSel;
		mask = mask >> 1;
		if (freqSel == 3'h0)
			mask = 8'hFF;
	end
	// divider and tick select
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			divCnt_r <= 8'h00;
			intTick <= 1'b0;
		end
		else
		begin
			if (fastEdge)
				divCnt_r <= divCnt_r + 8'h01;
			if (freqSel == 3'h0 && !lowFreqSrcSel)
				intTick <= slowEdge;
			else
				intTick <= fastEdge & ((divCnt_r & mask) == mask);
		end
	end
endmodule // int_postscaler

// ---- verification/power_clock_switch_sva.sv ----
`timescale 1ns/10ps
`include "power_clock_map.vh"
// watches the switcher from its ports; register fields are shadowed from apb writes
module power_clock_switch_sva (
	input wire clk_sys,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire sleepReq,
	input wire wakeReq,
	input wire wdtEnable,
	input wire failSafeEnable,
	input wire cpuClkEn,
	input wire periphClkEn,
	input wire priOscEn,
	input wire secOscEn,
	input wire intFastEn,
	input wire slowRcEn
);
	reg idle_r; // shadow of idle_on_sleep
	reg [1:0] sel_r; // shadow of clk_src_sel
	reg [2:0] freq_r; // shadow of int_freq_sel
	reg secEn_r; // shadow of sec_osc_enable
	reg lfs_r; // shadow of low_freq_src_sel
	reg asleep_r; // full sleep seen and not yet woken
	wire wrStb = psel && penable && pwrite;
	wire mapped = paddr == `OSC_CTRL_OFS || paddr == `SEC_TIMER_CTRL_OFS ||
		paddr == `OSC_TUNE_OFS || paddr == `MODE_STAT_OFS;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// shadows follow completed writes only; unmapped writes never reach them
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			idle_r <= 1'b0;
			sel_r <= `CLK_SEL_RST;
			freq_r <= `FREQ_SEL_RST;
			secEn_r <= 1'b0;
			lfs_r <= 1'b0;
			asleep_r <= 1'b0;
		end
		else
		begin
			if (wrStb && paddr == `OSC_CTRL_OFS)
			begin
				idle_r <= pwdata[`OSC_IDLE_BIT];
				sel_r <= pwdata[`OSC_SEL_HI:`OSC_SEL_LO];
				freq_r <= pwdata[`OSC_FREQ_HI:`OSC_FREQ_LO];
			end
			if (wrStb && paddr == `SEC_TIMER_CTRL_OFS)
				secEn_r <= pwdata[`SEC_EN_BIT];
			if (wrStb && paddr == `OSC_TUNE_OFS)
				lfs_r <= pwdata[`TUNE_LFS_BIT];
			// sleep wins over a wake in the same cycle
			if (sleepReq && !idle_r)
				asleep_r <= 1'b1;
			else if (wakeReq)
				asleep_r <= 1'b0;
		end
	end
	reset_state_a: assert property ($fell(reset) |-> priOscEn && !secOscEn && !cpuClkEn && !periphClkEn)
		else $error("outputs not at reset values");
	sleep_all_off_a: assert property (sleepReq && !idle_r |-> ##3 (!cpuClkEn && !periphClkEn && !priOscEn)[*4])
		else $error("clocks still running in sleep");
	idle_cpu_off_a: assert property (sleepReq && idle_r && !(sel_r == `SRC_SEC && !secEn_r) |-> ##3 (!cpuClkEn)[*4])
		else $error("cpu clocked in idle");
	cpu_with_periph_a: assert property (cpuClkEn |-> periphClkEn)
		else $error("cpu clocked without peripherals");
	unmapped_err_a: assert property (psel && penable && !pwrite && !mapped |-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	sec_refused_a: assert property (psel && penable && !pwrite && paddr == `MODE_STAT_OFS && !secEn_r |-> prdata[3:2] != `SRC_SEC)
		else $error("secondary run without oscillator enable");
	fast_off_a: assert property ((freq_r == 3'h0 && !lfs_r)[*3] |-> !intFastEn)
		else $error("fast internal output enabled at zero frequency");
	fast_on_a: assert property ((freq_r != 3'h0 && !asleep_r)[*4] |-> intFastEn)
		else $error("fast internal output not enabled");
	slow_kept_a: assert property ((wdtEnable || failSafeEnable)[*3] |-> slowRcEn)
		else $error("slow rc stopped while watchdog enabled");
	cover property (sleepReq && !idle_r);
	cover property (sleepReq && idle_r);
	cover property (psel && penable && pslverr);
endmodule // power_clock_switch_sva
bind power_clock_switch power_clock_switch_sva chk (.clk_sys(clk_sys), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pslverr(pslverr), .sleepReq(sleepReq), .wakeReq(wakeReq), .wdtEnable(wdtEnable),
	.failSafeEnable(failSafeEnable), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
	.priOscEn(priOscEn), .secOscEn(secOscEn), .intFastEn(intFastEn), .slowRcEn(slowRcEn));

// ---- verification/osc_model.sv ----
`timescale 1ns/10ps
// four oscillators; each stands still at low while its enable is off
module osc_model (
	input wire priOscEn,
	input wire secOscEn,
	input wire intFastEn,
	input wire slowRcEn,
	output reg priOscPin,
	output reg secOscPin,
	output reg intFastPin,
	output reg slowRcPin
);
	initial
	begin
		priOscPin = 1'b0;
		secOscPin = 1'b0;
		intFastPin = 1'b0;
		slowRcPin = 1'b0;
	end
	// half periods kept above two system clocks so the synchroniser sees every edge
	always #60 priOscPin = priOscEn ? ~priOscPin : 1'b0;
	always #170 secOscPin = secOscEn ? ~secOscPin : 1'b0;
	always #50 intFastPin = intFastEn ? ~intFastPin : 1'b0;
	always #230 slowRcPin = slowRcEn ? ~slowRcPin : 1'b0;
endmodule // osc_model

// ---- verification/power_clock_switch_test.sv ----
`timescale 1ns/10ps
`include "power_clock_map.vh"
`define CHECK(nm, x, got) begin n_checks = n_checks + 1; if ((got) !== (x)) begin \
	miscompares = miscompares + 1; $display("Error %s expected %h seen %h", nm, x, got); end end
module power_clock_switch_test;
	reg clk_sys = 1'b0;
	reg reset = 1'b1;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0000_0000;
	reg sleepReq = 1'b0;
	reg wakeReq = 1'b0;
	reg wdtEnable = 1'b0;
	reg priIsInternal = 1'b0; // primary taken from the internal block
	wire pready, pslverr, cpuClkEn, periphClkEn, priOscEn, secOscEn, intFastEn, slowRcEn;
	wire priOscPin, secOscPin, intFastPin, slowRcPin;
	wire [31:0] prdata;
	reg [31:0] q; // last read data
	reg e; // last error response
	reg [7:0] nC, nP; // clock enable pulse counts
	integer n_checks = 0;
	integer miscompares = 0;
	always #10 clk_sys = ~clk_sys;
	// short counts keep start-up and lock waits to a few dozen cycles
	power_clock_switch #(.PLL_LOCK_CYC(20), .OST_EDGES(8), .INT_STABLE_EDGES(4)) DUT (
		.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.sleepReq(sleepReq), .wakeReq(wakeReq), .crystalPllMode(1'b1),
		.priIsInternal(priIsInternal),
		.wdtEnable(wdtEnable), .failSafeEnable(1'b0), .priOscPin(priOscPin),
		.secOscPin(secOscPin), .intFastPin(intFastPin), .intSlowPin(slowRcPin),
		.cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .priOscEn(priOscEn),
		.secOscEn(secOscEn), .intFastEn(intFastEn), .slowRcEn(slowRcEn));
	osc_model osc (.priOscEn(priOscEn), .secOscEn(secOscEn), .intFastEn(intFastEn),
		.slowRcEn(slowRcEn), .priOscPin(priOscPin), .secOscPin(secOscPin),
		.intFastPin(intFastPin), .slowRcPin(slowRcPin));
	// one apb transfer, entered just after an edge; an idle cycle follows it
	task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] rd, output er);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk_sys);
			penable <= 1'b1;
			@(posedge clk_sys);
			while (pready !== 1'b1)
				@(posedge clk_sys);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		xfer(1'b1, a, d, q, e);
	endtask
	task chk(input [7:0] a, input [31:0] x);
		begin
			xfer(1'b0, a, 32'h0000_0000, q, e);
			`CHECK("read data", x, q)
		end
	endtask
	// polls the status word until the switch to source s has finished
	task waitSrc(input [1:0] s);
		integer i;
		begin
			q = 32'h0000_000F;
			for (i = 0; i < 300 && !(q[3:2] === s && q[4] === 1'b0); i = i + 1)
				xfer(1'b0, `MODE_STAT_OFS, 32'h0000_0000, q, e);
			`CHECK("source", s, q[3:2])
		end
	endtask
	// counts clock enable pulses over a window
	task count;
		begin
			nC = 8'h00;
			nP = 8'h00;
			repeat (40)
			begin
				@(posedge clk_sys);
				nC = nC + cpuClkEn;
				nP = nP + periphClkEn;
			end
		end
	endtask
	task close_out;
		begin
			$display("checks %0d miscompares %0d", n_checks, miscompares);
			if (miscompares == 0 && n_checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// a hang ends the run as a failure
	initial
	begin
		repeat (60000) @(posedge clk_sys);
		miscompares = miscompares + 1;
		close_out;
	end
	initial
	begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		chk(`OSC_CTRL_OFS, 32'h0000_0048);
		wr(`OSC_CTRL_OFS, 32'h0000_004C);
		chk(`OSC_CTRL_OFS, 32'h0000_0048);
		xfer(1'b0, 8'h10, 32'h0000_0000, q, e);
		`CHECK("unmapped error", 1'b1, e)
		wr(`OSC_CTRL_OFS, 32'h0000_0041);
		repeat (80) @(posedge clk_sys);
		chk(`MODE_STAT_OFS, 32'h0000_0000);
		chk(`SEC_TIMER_CTRL_OFS, 32'h0000_0000);
		wr(`OSC_CTRL_OFS, 32'h0000_0040);
		wr(`SEC_TIMER_CTRL_OFS, 32'h0000_0008);
		repeat (60) @(posedge clk_sys);
		wr(`OSC_CTRL_OFS, 32'h0000_0041);
		waitSrc(`SRC_SEC);
		chk(`OSC_CTRL_OFS, 32'h0000_0041);
		chk(`SEC_TIMER_CTRL_OFS, 32'h0000_0048);
		`CHECK("primary enable", 1'b0, priOscEn)
		wr(`OSC_CTRL_OFS, 32'h0000_0040);
		waitSrc(`SRC_PRI);
		chk(`OSC_CTRL_OFS, 32'h0000_0048);
		chk(`SEC_TIMER_CTRL_OFS, 32'h0000_0008);
		`CHECK("secondary enable", 1'b1, secOscEn)
		// restart the timer osc and select it before it oscillates: clocks must hold
		wr(`SEC_TIMER_CTRL_OFS, 32'h0000_0000);
		repeat (20) @(posedge clk_sys);
		wr(`SEC_TIMER_CTRL_OFS, 32'h0000_0008);
		wr(`OSC_CTRL_OFS, 32'h0000_0041);
		// hold plus three incoming edges outlasts this 40-cycle window
		@(posedge clk_sys);
		count;
		`CHECK("held clocks", 16'h0000, {nC, nP})
		waitSrc(`SRC_SEC);
		wr(`OSC_CTRL_OFS, 32'h0000_0040);
		waitSrc(`SRC_PRI);
		wr(`OSC_CTRL_OFS, 32'h0000_0072);
		waitSrc(`SRC_INT);
		chk(`OSC_CTRL_OFS, 32'h0000_0076);
		`CHECK("primary enable", 1'b0, priOscEn)
		wr(`OSC_CTRL_OFS, 32'h0000_0002);
		repeat (20) @(posedge clk_sys);
		chk(`OSC_CTRL_OFS, 32'h0000_0002);
		// low-frequency source select alone must wake the fast output
		wr(`OSC_TUNE_OFS, 32'h0000_0080);
		repeat (40) @(posedge clk_sys);
		chk(`OSC_TUNE_OFS, 32'h0000_0080);
		chk(`OSC_CTRL_OFS, 32'h0000_0006);
		wr(`OSC_TUNE_OFS, 32'h0000_0000);
		wr(`OSC_CTRL_OFS, 32'h0000_0012);
		repeat (40) @(posedge clk_sys);
		chk(`OSC_CTRL_OFS, 32'h0000_0016);
		wr(`OSC_CTRL_OFS, 32'h0000_0010);
		waitSrc(`SRC_PRI);
		chk(`OSC_CTRL_OFS, 32'h0000_0018);
		wdtEnable <= 1'b1;
		sleepReq <= 1'b1;
		@(posedge clk_sys);
		sleepReq <= 1'b0;
		repeat (8) @(posedge clk_sys);
		count;
		`CHECK("sleep clocks", 16'h0000, {nC, nP})
		chk(`MODE_STAT_OFS, 32'h0000_0001);
		chk(`OSC_CTRL_OFS, 32'h0000_0010);
		`CHECK("slow rc enable", 1'b1, slowRcEn)
		wakeReq <= 1'b1;
		@(posedge clk_sys);
		wakeReq <= 1'b0;
		repeat (200) @(posedge clk_sys);
		chk(`OSC_CTRL_OFS, 32'h0000_0018);
		wr(`OSC_CTRL_OFS, 32'h0000_0090);
		sleepReq <= 1'b1;
		@(posedge clk_sys);
		sleepReq <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk(`MODE_STAT_OFS, 32'h0000_0002);
		chk(`OSC_CTRL_OFS, 32'h0000_0098);
		count;
		`CHECK("idle cpu clock", 8'h00, nC)
		`CHECK("idle peripheral clock", 1'b1, nP != 8'h00)
		// internal block as primary: both flags may stand in primary idle
		priIsInternal <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(`OSC_CTRL_OFS, 32'h0000_009C);
		close_out;
	end
endmodule // power_clock_switch_test
